// ===== core/iocx_core.sv
// Routing and card selection logic of one chained I/O extender unit
module iocx_core (
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    // Upstream connector
    input wire logic [11:0] UP_DATA_IN,
    input wire logic [3:0] UP_ADDR,
    input wire logic [14:0] UP_UNIT_SEL,
    input wire logic UP_INPUT_MODE,
    input wire logic UP_GATE,
    output logic [11:0] UP_DATA_OUT,
    output logic UP_DATA_OE,
    output logic UP_FLAG,
    // Downstream connector
    output logic [11:0] DN_DATA,
    output logic DN_DATA_OE,
    output logic [3:0] DN_ADDR,
    output logic [13:0] DN_UNIT_SEL,
    output logic DN_INPUT_MODE,
    output logic DN_GATE,
    input wire logic [11:0] DN_RET_DATA,
    input wire logic DN_RET_OE,
    input wire logic DN_FLAG_IN,
    // Card slots
    output logic [14:0] SLOT_PART_EN,
    output logic [14:0] SLOT_WR_EN,
    output logic [11:0] SLOT_WR_DATA,
    output logic [14:0] SLOT_RD_SEL,
    input wire logic [179:0] SLOT_RD_DATA,
    input wire logic CARD_READY
);

    localparam int DW = iocx_pkg::DATA_W;
    localparam int AW = iocx_pkg::ADDR_W;
    localparam int SN = iocx_pkg::SLOT_N;
    localparam int PW = iocx_pkg::PIN_W;

    typedef struct packed {
        logic [PW-1:0] s1;
        logic [PW-1:0] s2;
        logic [PW-1:0] s3;
        logic [PW-1:0] pin;
        logic gate_q;
        iocx_pkg::iocx_state_e st;
        logic [DW-1:0] up_data_out;
        logic up_data_oe;
        logic up_flag;
        logic [DW-1:0] dn_data;
        logic dn_data_oe;
        logic [AW-1:0] dn_addr;
        logic [iocx_pkg::SEL_W-2:0] dn_sel;
        logic dn_mode;
        logic dn_gate;
        logic [SN-1:0] part_en;
        logic [SN-1:0] wr_en;
        logic [DW-1:0] wr_data;
        logic [SN-1:0] rd_sel;
    } iocx_core_s;

    iocx_core_s r;
    iocx_core_s next_r;

    // ------------------------------------------------------------
    // Filtered pin fields
    // ------------------------------------------------------------
    logic [PW-1:0] pin_vec;
    logic [DW-1:0] f_data;
    logic [AW-1:0] f_addr;
    logic [iocx_pkg::SEL_W-1:0] f_sel;
    logic f_mode;
    logic f_gate;
    logic [DW-1:0] f_dn_data;
    logic f_dn_oe;
    logic f_dn_flag;
    logic gate_rise;
    logic unit_me;

    assign pin_vec = {DN_FLAG_IN, DN_RET_OE, DN_RET_DATA, UP_GATE, UP_INPUT_MODE,
                      UP_UNIT_SEL, UP_ADDR, UP_DATA_IN};
    assign f_data = r.pin[iocx_pkg::UP_DATA_LSB +: DW];
    assign f_addr = r.pin[iocx_pkg::UP_ADDR_LSB +: AW];
    assign f_sel = r.pin[iocx_pkg::UP_SEL_LSB +: iocx_pkg::SEL_W];
    assign f_mode = r.pin[iocx_pkg::UP_MODE_BIT];
    assign f_gate = r.pin[iocx_pkg::UP_GATE_BIT];
    assign f_dn_data = r.pin[iocx_pkg::DN_DATA_LSB +: DW];
    assign f_dn_oe = r.pin[iocx_pkg::DN_OE_BIT];
    assign f_dn_flag = r.pin[iocx_pkg::DN_FLAG_BIT];
    assign gate_rise = f_gate & ~r.gate_q;
    assign unit_me = f_sel[0];

    // ------------------------------------------------------------
    // Output word FIFO
    // ------------------------------------------------------------
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [iocx_pkg::WORD_W-1:0] fifo_out;

    // Only words for this unit outside input mode go to output cards
    assign fifo_in_valid = gate_rise & unit_me & ~f_mode;

    iocx_fifo #(
        .W(iocx_pkg::WORD_W),
        .D(iocx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst(RESET),
        .ce(CLK_EN),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({f_addr, f_data}),
        .out_valid(fifo_out_valid),
        .out_ready(CARD_READY),
        .out_data(fifo_out)
    );

    // ------------------------------------------------------------
    // Per-slot address decode and card data selection
    // ------------------------------------------------------------
    logic [SN-1:0] hit_in;
    logic [SN-1:0] hit_out;
    logic [SN:0][DW-1:0] rd_acc;
    logic [DW-1:0] rd_word;

    assign rd_acc[0] = '0;
    genvar k;
    generate
        for (k = 0; k < SN; k++) begin : g_slot
            // Slot k answers address k only; value 15 selects no card
            assign hit_in[k] = (f_addr == AW'(k));
            assign hit_out[k] = (fifo_out[iocx_pkg::WORD_W-1 -: AW] == AW'(k));
            assign rd_acc[k+1] = rd_acc[k] | (hit_in[k] ? SLOT_RD_DATA[k*DW +: DW] : '0);
        end
    endgenerate
    assign rd_word = rd_acc[SN];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        // Three-stage pin filter, a bit moves once stages two and three agree
        next_r.s1 = pin_vec;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.pin = (r.s3 & ~(r.s2 ^ r.s3)) | (r.pin & (r.s2 ^ r.s3));
        next_r.gate_q = f_gate;
        // Chain forwarding, select line one is consumed here
        next_r.dn_data = f_data;
        next_r.dn_addr = f_addr;
        next_r.dn_sel = f_sel[iocx_pkg::SEL_W-1:1];
        next_r.dn_mode = f_mode;
        next_r.dn_gate = f_gate;
        next_r.dn_data_oe = ~f_mode; // Release lines so a later unit can return data
        next_r.part_en = {SN{unit_me}};
        // Drain one word per ready card cycle, one slot strobed at a time
        next_r.wr_en = '0;
        if (fifo_out_valid && CARD_READY) begin
            next_r.wr_en = hit_out;
            next_r.wr_data = fifo_out[DW-1:0];
        end
        // Busy while words wait, the FIFO is full, or a later unit is busy
        next_r.up_flag = ~fifo_in_ready | fifo_out_valid | f_dn_flag;
        case (r.st)
            iocx_pkg::ST_IDLE: begin
                next_r.up_data_out = f_dn_data;
                next_r.up_data_oe = f_dn_oe & f_mode;
                next_r.rd_sel = '0;
                if (gate_rise && unit_me && f_mode) begin
                    next_r.st = iocx_pkg::ST_RETURN;
                    next_r.rd_sel = hit_in;
                end
            end
            iocx_pkg::ST_RETURN: begin
                if (!f_mode || !unit_me) begin
                    next_r.st = iocx_pkg::ST_IDLE;
                    next_r.rd_sel = '0;
                    next_r.up_data_oe = 1'b0;
                end else begin
                    // Card data replaces programmed data on the shared lines
                    next_r.up_data_out = rd_word;
                    next_r.up_data_oe = 1'b1;
                    if (gate_rise) begin
                        next_r.rd_sel = hit_in;
                    end
                end
            end
            default: begin
                next_r.st = iocx_pkg::ST_IDLE;
            end
        endcase
    end

    // State register, synchronous reset, frozen while the enable is low
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            r <= '0;
            r.up_flag <= iocx_pkg::FLAG_RST;
            r.dn_data_oe <= iocx_pkg::DN_OE_RST;
        end else if (CLK_EN) begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign UP_DATA_OUT = r.up_data_out;
    assign UP_DATA_OE = r.up_data_oe;
    assign UP_FLAG = r.up_flag;
    assign DN_DATA = r.dn_data;
    assign DN_DATA_OE = r.dn_data_oe;
    assign DN_ADDR = r.dn_addr;
    assign DN_UNIT_SEL = r.dn_sel;
    assign DN_INPUT_MODE = r.dn_mode;
    assign DN_GATE = r.dn_gate;
    assign SLOT_PART_EN = r.part_en;
    assign SLOT_WR_EN = r.wr_en;
    assign SLOT_WR_DATA = r.wr_data;
    assign SLOT_RD_SEL = r.rd_sel;

    // ------------------------------------------------------------
    // Assertions, dropped whenever the enable pauses the block
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET || !CLK_EN);

    sequence out_word_s;
        gate_rise && unit_me && !f_mode && fifo_in_ready;
    endsequence

    sequence in_word_s;
        r.st == iocx_pkg::ST_IDLE && gate_rise && unit_me && f_mode;
    endsequence

    fwd_select_a: assert property (1'b1 |=> DN_UNIT_SEL == $past(f_sel[14:1]))
        else $error("forwarded select lines wrong");
    part_enable_a: assert property (1'b1 |=> SLOT_PART_EN == {SN{$past(unit_me)}})
        else $error("partial enable does not follow unit select");
    out_busy_a: assert property (out_word_s |-> ##2 UP_FLAG)
        else $error("flag not busy after a queued word");
    in_enter_a: assert property (in_word_s |=> r.st == iocx_pkg::ST_RETURN
        && SLOT_RD_SEL == $past(hit_in))
        else $error("input word did not select one card");
    return_drive_a: assert property ((r.st == iocx_pkg::ST_RETURN && f_mode && unit_me)
        |=> UP_DATA_OE && UP_DATA_OUT == $past(rd_word))
        else $error("card data not driven upstream");
    no_drive_a: assert property (!f_mode |=> !UP_DATA_OE)
        else $error("data lines driven outside input mode");
    one_card_a: assert property ($onehot0(SLOT_WR_EN) && $onehot0(SLOT_RD_SEL))
        else $error("more than one card enabled");
    card_write_a: assert property ((fifo_out_valid && CARD_READY && fifo_out[15:12] != 4'hf)
        |=> $onehot(SLOT_WR_EN) && SLOT_WR_DATA == $past(fifo_out[11:0]))
        else $error("queued word not written to its slot");
    pass_up_a: assert property ((r.st == iocx_pkg::ST_IDLE && f_mode && f_dn_oe)
        |=> UP_DATA_OE && UP_DATA_OUT == $past(f_dn_data))
        else $error("downstream return not passed upstream");

endmodule

// ===== core/iocx_pkg.sv
// Shared constants and types for the I/O chain extender routing block
package iocx_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int DATA_W = 12;
    localparam int ADDR_W = 4;
    localparam int SEL_W = 15;
    localparam int SLOT_N = 15;
    localparam int WORD_W = DATA_W + ADDR_W;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------
    // Field positions in the synchronised pin vector
    // ------------------------------------------------------------
    localparam int UP_DATA_LSB = 0;
    localparam int UP_ADDR_LSB = 12;
    localparam int UP_SEL_LSB = 16;
    localparam int UP_MODE_BIT = 31;
    localparam int UP_GATE_BIT = 32;
    localparam int DN_DATA_LSB = 33;
    localparam int DN_OE_BIT = 45;
    localparam int DN_FLAG_BIT = 46;
    localparam int PIN_W = 47;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic FLAG_RST = 1'b1;
    localparam logic DN_OE_RST = 1'b0;

    // ------------------------------------------------------------
    // Input-mode return sequencer
    // ------------------------------------------------------------
    typedef enum logic {
        ST_IDLE,
        ST_RETURN
    } iocx_state_e;

endpackage

// ===== core/iocx_fifo.sv
// Word FIFO between the upstream word strobe and the output card slots
module iocx_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } iocx_fifo_s;

    iocx_fifo_s r;
    iocx_fifo_s next_r;
    logic do_push;
    logic do_pop;

    // Honest flags straight from the fill count
    assign in_ready = (r.cnt != (AW + 1)'(D));
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rp];
    assign do_push = in_valid & in_ready;
    assign do_pop = out_valid & out_ready;

    // Pointer and count update, wraps on power-of-two depth
    always_comb begin
        next_r = r;
        if (do_push) begin
            next_r.mem[r.wp] = in_data;
            next_r.wp = r.wp + 1'b1;
        end
        if (do_pop) begin
            next_r.rp = r.rp + 1'b1;
        end
        if (do_push && !do_pop) begin
            next_r.cnt = r.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            next_r.cnt = r.cnt - 1'b1;
        end
    end

    // State register, frozen while the enable is low
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

endmodule

// ===== bench/iocx_next_unit.sv
// Behavioural model of the next extender unit on the downstream connector
module iocx_next_unit (
    // Clock
    input wire logic clk,
    // Lines forwarded by the unit under test
    input wire logic sel,
    input wire logic mode,
    // Bench controls
    input wire logic busy,
    input wire logic [11:0] value,
    // Return lines
    output logic [11:0] ret_data,
    output logic ret_oe,
    output logic flag
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Return path
    // ------------------------------------------------------------
    initial begin
        ret_data = 12'h0;
        ret_oe = 1'b0;
        flag = 1'b0;
    end

    // Released lines toggle so a stale value never passes for a return
    always @(posedge clk) begin
        ret_oe <= sel & mode;
        ret_data <= (sel & mode) ? value : ~ret_data;
        flag <= busy;
    end
endmodule

// ===== bench/io_chain_extender_routing_test.sv
// Self-checking bench for the I/O chain extender routing block
module io_chain_extender_routing_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic CORE_CLK = 1'b0;
    logic RESET = 1'b1;
    logic en = 1'b1;
    logic [11:0] UP_DATA_IN = 12'h0;
    logic [3:0] UP_ADDR = 4'h0;
    logic [14:0] UP_UNIT_SEL = 15'h0;
    logic UP_INPUT_MODE = 1'b0;
    logic UP_GATE = 1'b0;
    logic [179:0] SLOT_RD_DATA = '0;
    logic CARD_READY = 1'b1;
    logic busy = 1'b0;
    logic stall = 1'b0;
    logic rand_rdy = 1'b0;
    logic [11:0] value = 12'h0;
    logic [11:0] UP_DATA_OUT, DN_DATA, SLOT_WR_DATA, ret_data;
    logic [14:0] SLOT_PART_EN, SLOT_WR_EN, SLOT_RD_SEL;
    logic [13:0] DN_UNIT_SEL;
    logic [3:0] DN_ADDR;
    logic UP_DATA_OE, UP_FLAG, DN_DATA_OE, DN_INPUT_MODE, DN_GATE, ret_oe, flag;
    logic [31:0] seed = 32'h3df8;
    logic [31:0] r;
    logic [15:0] expq[$];
    logic [15:0] exp_w;
    int fails = 0;
    int tests_run = 0;

    iocx_core DUT (.CORE_CLK(CORE_CLK), .RESET(RESET), .CLK_EN(en),
        .UP_DATA_IN(UP_DATA_IN), .UP_ADDR(UP_ADDR), .UP_UNIT_SEL(UP_UNIT_SEL),
        .UP_INPUT_MODE(UP_INPUT_MODE), .UP_GATE(UP_GATE), .UP_DATA_OUT(UP_DATA_OUT),
        .UP_DATA_OE(UP_DATA_OE), .UP_FLAG(UP_FLAG), .DN_DATA(DN_DATA),
        .DN_DATA_OE(DN_DATA_OE), .DN_ADDR(DN_ADDR), .DN_UNIT_SEL(DN_UNIT_SEL),
        .DN_INPUT_MODE(DN_INPUT_MODE), .DN_GATE(DN_GATE), .DN_RET_DATA(ret_data),
        .DN_RET_OE(ret_oe), .DN_FLAG_IN(flag), .SLOT_PART_EN(SLOT_PART_EN),
        .SLOT_WR_EN(SLOT_WR_EN), .SLOT_WR_DATA(SLOT_WR_DATA), .SLOT_RD_SEL(SLOT_RD_SEL),
        .SLOT_RD_DATA(SLOT_RD_DATA), .CARD_READY(CARD_READY));

    iocx_next_unit next_unit (.clk(CORE_CLK), .sel(DN_UNIT_SEL[0]), .mode(DN_INPUT_MODE),
        .busy(busy), .value(value), .ret_data(ret_data), .ret_oe(ret_oe), .flag(flag));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #50 CORE_CLK = ~CORE_CLK;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task end_of_test();
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Card side stalls at random or hard, to back the FIFO up
    always @(posedge CORE_CLK) begin
        if (rand_rdy) begin
            void'(rnd());
        end
        CARD_READY <= !stall && (!rand_rdy || seed[3]);
    end

    // Every card write is matched against the queue of accepted words
    always @(negedge CORE_CLK) begin
        if (!RESET && SLOT_WR_EN != 15'h0) begin
            if (expq.size() == 0) begin
                check(1'b0, "unexpected card write");
            end else begin
                exp_w = expq.pop_front();
                check(SLOT_WR_EN === (15'h1 << exp_w[15:12]), "write strobe");
                check(SLOT_WR_DATA === exp_w[11:0], "write data");
            end
        end
    end

    // One word per strobe; gate held and released long enough for the pin filter
    task put_word(input logic [3:0] a, input logic [11:0] d, input bit keep);
        UP_ADDR <= a;
        UP_DATA_IN <= d;
        repeat (4) @(posedge CORE_CLK);
        UP_GATE <= 1'b1;
        if (keep && a != 4'hf) begin
            expq.push_back({a, d});
        end
        repeat (6) @(posedge CORE_CLK);
        #10;
        check(DN_GATE === 1'b1, "gate forward");
        @(posedge CORE_CLK);
        UP_GATE <= 1'b0;
        repeat (5) @(posedge CORE_CLK);
    endtask

    task drain();
        for (int n = 0; n < 300 && expq.size() != 0; n++) begin
            @(posedge CORE_CLK);
        end
        if (expq.size() != 0) begin
            check(1'b0, "drain timeout");
            end_of_test();
        end
    endtask

    initial begin
        #6000000;
        check(1'b0, "run timeout");
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge CORE_CLK);
        #10;
        check(UP_FLAG === 1'b1 && UP_DATA_OE === 1'b0, "reset state");
        @(posedge CORE_CLK);
        RESET <= 1'b0;
        // Random pass-through of select, address, data, mode and flag
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            UP_UNIT_SEL <= r[14:0];
            UP_ADDR <= r[18:15];
            UP_DATA_IN <= r[30:19];
            UP_INPUT_MODE <= r[31];
            busy <= r[2];
            value <= r[27:16];
            repeat (16) @(posedge CORE_CLK);
            #10;
            check(DN_UNIT_SEL === r[14:1], "select forward");
            check(SLOT_PART_EN === {15{r[0]}}, "partial enable");
            check(DN_ADDR === r[18:15] && DN_INPUT_MODE === r[31], "fwd");
            check(DN_DATA_OE === !r[31], "data enable");
            check(r[31] || DN_DATA === r[30:19], "data forward");
            check(UP_FLAG === r[2], "flag");
            check(!(r[31] && r[1]) || (UP_DATA_OE === 1'b1 && UP_DATA_OUT === r[27:16]),
                "chain return");
            @(posedge CORE_CLK);
        end
        // Every slot address written, card side stalling at random
        UP_INPUT_MODE <= 1'b0;
        UP_UNIT_SEL <= 15'h1;
        busy <= 1'b0;
        rand_rdy <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            put_word(4'(a), 12'(rnd()), 1'b1);
        end
        drain();
        rand_rdy <= 1'b0;
        // Word for another unit must not reach these cards
        UP_UNIT_SEL <= 15'h2;
        put_word(4'h3, 12'h5a5, 1'b0);
        // Cards stalled: eight words fit, the rest are dropped
        UP_UNIT_SEL <= 15'h1;
        stall <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            put_word(4'(i), 12'(rnd()), i < 8);
        end
        #10;
        check(UP_FLAG === 1'b1, "busy when full");
        // Paused block must ignore a dropped select line; cards stay stalled meanwhile
        @(posedge CORE_CLK);
        en <= 1'b0;
        UP_UNIT_SEL <= 15'h0;
        repeat (8) @(posedge CORE_CLK);
        #10;
        check(SLOT_PART_EN === 15'h7fff && UP_FLAG === 1'b1, "frozen while paused");
        @(posedge CORE_CLK);
        UP_UNIT_SEL <= 15'h1;
        en <= 1'b1;
        @(posedge CORE_CLK);
        stall <= 1'b0;
        drain();
        repeat (12) @(posedge CORE_CLK);
        #10;
        check(UP_FLAG === 1'b0, "ready when empty");
        // Input mode: each card's data returned upstream
        @(posedge CORE_CLK);
        UP_INPUT_MODE <= 1'b1;
        SLOT_RD_DATA <= 180'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
        for (int k = 0; k < 15; k++) begin
            put_word(4'(k), 12'h0, 1'b0);
            #10;
            check(SLOT_RD_SEL === (15'h1 << k), "read select");
            check(UP_DATA_OE === 1'b1 && DN_DATA_OE === 1'b0, "return drive");
            check(UP_DATA_OUT === SLOT_RD_DATA[12*k +: 12], "return data");
            @(posedge CORE_CLK);
        end
        UP_INPUT_MODE <= 1'b0;
        repeat (8) @(posedge CORE_CLK);
        #10;
        check(UP_DATA_OE === 1'b0, "release lines");
        end_of_test();
    end
endmodule
